// File: upwin_pkg.sv
package upwin_pkg;

  // ****************************************
  // Register map (configuration dword byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_UPWIN_CTRL = 8'h48;
  localparam logic [7:0] OFF_PREEMPT = 8'h4c;
  localparam logic [7:0] OFF_BASE_LIMIT = 8'h50;
  localparam logic [7:0] OFF_BASE_UPPER = 8'h54;
  localparam logic [7:0] OFF_LIMIT_UPPER = 8'h58;
  localparam logic [7:0] OFF_SERR_MASK = 8'h64;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int UPWIN_EN_BIT = 16;
  localparam int PREEMPT_LSB = 28;
  localparam int BASE_LSB = 4;
  localparam int LIMIT_LSB = 20;
  localparam int CAP_BASE_LSB = 0;
  localparam int CAP_LIMIT_LSB = 16;
  localparam logic [3:0] ADDR_CAP_64 = 4'h1;
  localparam logic [3:0] PREEMPT_RESET = 4'h0;
  localparam logic [11:0] BASE_RESET = 12'h000;
  localparam logic [11:0] LIMIT_RESET = 12'h000;
  localparam logic [31:0] UPPER_RESET = 32'h0000_0000;
  localparam logic [7:0] SERR_MASK_RESET = 8'h00;
  // Writable mask bits 6:1; bits 0 and 7 are fixed zero
  localparam logic [7:0] SERR_MASK_RW = 8'h7e;
  localparam logic [19:0] LOW_ZERO = 20'h00000;
  localparam logic [19:0] LOW_ONES = 20'hfffff;

  // ****************************************
  // Preemption codes and delays
  // ****************************************
  localparam logic [3:0] PRE_C0 = 4'h0;
  localparam logic [3:0] PRE_C1 = 4'h1;
  localparam logic [3:0] PRE_C2 = 4'h2;
  localparam logic [3:0] PRE_C3 = 4'h3;
  localparam logic [3:0] PRE_C4 = 4'h4;
  localparam logic [3:0] PRE_C5 = 4'h5;
  localparam logic [3:0] PRE_C6 = 4'h6;
  localparam logic [3:0] PRE_C7 = 4'h7;
  localparam logic [6:0] DLY_0 = 7'd0;
  localparam logic [6:0] DLY_1 = 7'd1;
  localparam logic [6:0] DLY_2 = 7'd2;
  localparam logic [6:0] DLY_4 = 7'd4;
  localparam logic [6:0] DLY_8 = 7'd8;
  localparam logic [6:0] DLY_16 = 7'd16;
  localparam logic [6:0] DLY_32 = 7'd32;
  localparam logic [6:0] DLY_64 = 7'd64;
  localparam logic [6:0] CNT_ONE = 7'd1;

  // Serr event bit positions in the 8-bit event vector
  localparam int EV_PW_PARITY = 1;
  localparam int EV_PW_NODELIV = 2;
  localparam int EV_PW_TABORT = 3;
  localparam int EV_PW_MABORT = 4;
  localparam int EV_DW_NODELIV = 5;
  localparam int EV_DR_NODATA = 6;

  // ****************************************
  // Carriers
  // ****************************************
  // Configuration access from the primary side
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } cfg_req_t;

  // Secondary bus observation for preemption
  typedef struct packed {
    logic frame;
    logic other_req;
  } sec_bus_t;

  // Preemption timer states
  typedef enum logic [2:0] {
    PT_IDLE = 3'b001,
    PT_COUNT = 3'b010,
    PT_ARMED = 3'b100
  } pt_state_t;

  // Map a preemption code to its delay in cycles
  function automatic logic [6:0] preempt_delay(input logic [3:0] code);
    case (code)
      PRE_C0: preempt_delay = DLY_0;
      PRE_C1: preempt_delay = DLY_1;
      PRE_C2: preempt_delay = DLY_2;
      PRE_C3: preempt_delay = DLY_4;
      PRE_C4: preempt_delay = DLY_8;
      PRE_C5: preempt_delay = DLY_16;
      PRE_C6: preempt_delay = DLY_32;
      PRE_C7: preempt_delay = DLY_64;
      default: preempt_delay = DLY_0;
    endcase
  endfunction

  // Byte-enable merge of a write into an old word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      be_merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

endpackage

// File: preempt_timer.sv
module preempt_timer
  import upwin_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] code,
  input wire sec_bus_t bus,
  output logic preempt
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    pt_state_t st;
    logic [6:0] cnt;
    logic pre;
  } pt_regs_t;

  pt_regs_t s_reg; // Registered state
  pt_regs_t s_next; // Next state
  logic [6:0] dly; // Decoded delay

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    // R21: code 0011 gives four
    dly = preempt_delay(code);
    s_next.pre = 1'b0;
    case (s_reg.st)
      PT_IDLE: begin
        // R5: top bit disables; zero immediate
        if (bus.frame && !code[3]) begin
          if (dly == DLY_0) begin
            s_next.st = PT_ARMED;
          end else if (dly == CNT_ONE) begin
            s_next.st = PT_ARMED;
          end else begin
            s_next.st = PT_COUNT;
            s_next.cnt = dly - CNT_ONE;
          end
        end
      end
      PT_COUNT: begin
        // R6 R7 R8: count delay cycles
        if (!bus.frame || code[3]) begin
          s_next.st = PT_IDLE;
        end else if (s_reg.cnt == CNT_ONE) begin
          s_next.st = PT_ARMED;
        end else begin
          s_next.cnt = s_reg.cnt - CNT_ONE;
        end
      end
      PT_ARMED: begin
        if (!bus.frame || code[3]) begin
          s_next.st = PT_IDLE;
        end
      end
      default: s_next.st = PT_IDLE;
    endcase
    // R23: drop grant when others request
    s_next.pre = (s_next.st == PT_ARMED) && bus.frame && bus.other_req && !code[3];
  end

  // ****************************************
  // Register
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '{st: PT_IDLE, cnt: DLY_0, pre: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign preempt = s_reg.pre;

endmodule

// File: upwin_window_cmp.sv
module upwin_window_cmp
  import upwin_pkg::*;
(
  input wire logic [63:0] addr,
  input wire logic [63:0] base,
  input wire logic [63:0] limit,
  output logic hit
);

  // R22: inclusive 1 MB range
  assign hit = (addr >= base) && (addr <= limit);

endmodule

// File: upwin_cfg.sv
// Behaviour
// R1: disabled window: all outside downstream go upstream
// R2: enabled window: forward only within base/limit
// R3: reserved bits read zero, ignore writes
// R4: bits 31:28 set preemption delay
// R5: 1xxx off; 0000 immediate, reset value
// R6: codes 0001, 0010 give one, two cycles
// R7: codes 0100, 0101 give eight, sixteen cycles
// R8: codes 0110, 0111 give 32, 64 cycles
// R9: capability nibbles read one (64-bit)
// R10: base field bits 15:4 read/write, reset zero
// R11: limit field bits 31:20 read/write
// R12: base upper word read/write, reset zero
// R13: limit upper word read/write, reset zero
// R14: mask zero reports, one suppresses error
// R15: mask bit 1 gates posted-write parity
// R16: mask bit 2 gates posted-write non-delivery
// R17: mask bit 3 gates posted-write target abort
// R18: mask bit 4 gates posted-write master abort
// R19: mask bit 5 gates delayed-write non-delivery
// R20: mask bit 6 gates delayed-read no data
// R21: code 0011 gives four cycles
// R22: inclusive hit, base zeros, limit ones
// R23: preempt grant when another master requests
module upwin_cfg
  import upwin_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire cfg_req_t CFG_REQ,
  output logic [31:0] CFG_RDATA,
  output logic CFG_RVALID,
  input wire logic [63:0] SEC_ADDR,
  input wire logic SEC_MEM_VALID,
  input wire logic DOWN_WIN_HIT,
  output logic UPSTREAM_CLAIM,
  input wire sec_bus_t SEC_BUS,
  output logic PREEMPT_GRANT,
  input wire logic [7:0] SERR_EVENTS,
  input wire logic system_error_report_enable,
  output logic primary_system_error_out
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic win_en;
    logic [3:0] preempt_code;
    logic [11:0] base_lo;
    logic [11:0] limit_lo;
    logic [31:0] base_hi;
    logic [31:0] limit_hi;
    logic [7:0] serr_mask;
    logic [31:0] rdata;
    logic rvalid;
    logic claim;
    logic serr;
  } cfg_regs_t;

  cfg_regs_t s_reg; // Registered state
  cfg_regs_t s_next; // Next state
  logic [63:0] base_full; // Base with low bits zero
  logic [63:0] limit_full; // Limit with low bits ones
  logic win_hit; // Address inside upstream window
  logic preempt; // Timer output
  logic [31:0] wr_word; // Merged write word
  logic [31:0] rd_word; // Current read word

  // ****************************************
  // Window compare
  // ****************************************
  // R22: build inclusive bounds
  assign base_full = {s_reg.base_hi, s_reg.base_lo, LOW_ZERO};
  assign limit_full = {s_reg.limit_hi, s_reg.limit_lo, LOW_ONES};

  upwin_window_cmp u_cmp (
    .addr(SEC_ADDR),
    .base(base_full),
    .limit(limit_full),
    .hit(win_hit)
  );

  // ****************************************
  // Preemption timer
  // ****************************************
  // R4: code field drives the timer
  preempt_timer u_pt (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .code(s_reg.preempt_code),
    .bus(SEC_BUS),
    .preempt(preempt)
  );

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    rd_word = 32'h0000_0000;
    // R3: unlisted bits stay zero
    case (CFG_REQ.addr)
      OFF_UPWIN_CTRL: rd_word[UPWIN_EN_BIT] = s_reg.win_en;
      OFF_PREEMPT: rd_word[PREEMPT_LSB +: 4] = s_reg.preempt_code;
      OFF_BASE_LIMIT: begin
        // R9: capability nibbles fixed
        rd_word[CAP_BASE_LSB +: 4] = ADDR_CAP_64;
        rd_word[CAP_LIMIT_LSB +: 4] = ADDR_CAP_64;
        rd_word[BASE_LSB +: 12] = s_reg.base_lo;
        rd_word[LIMIT_LSB +: 12] = s_reg.limit_lo;
      end
      OFF_BASE_UPPER: rd_word = s_reg.base_hi;
      OFF_LIMIT_UPPER: rd_word = s_reg.limit_hi;
      OFF_SERR_MASK: rd_word[7:0] = s_reg.serr_mask;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    wr_word = be_merge(rd_word, CFG_REQ.wdata, CFG_REQ.be);
    s_next.rvalid = CFG_REQ.rd;
    s_next.rdata = CFG_REQ.rd ? rd_word : 32'h0000_0000;
    if (CFG_REQ.wr) begin
      case (CFG_REQ.addr)
        OFF_UPWIN_CTRL: s_next.win_en = wr_word[UPWIN_EN_BIT];
        OFF_PREEMPT: s_next.preempt_code = wr_word[PREEMPT_LSB +: 4];
        OFF_BASE_LIMIT: begin
          // R10: base field writable
          s_next.base_lo = wr_word[BASE_LSB +: 12];
          // R11: limit field writable
          s_next.limit_lo = wr_word[LIMIT_LSB +: 12];
        end
        // R12: base upper word
        OFF_BASE_UPPER: s_next.base_hi = wr_word;
        // R13: limit upper word
        OFF_LIMIT_UPPER: s_next.limit_hi = wr_word;
        // R3: reserved mask bits ignored
        OFF_SERR_MASK: s_next.serr_mask = wr_word[7:0] & SERR_MASK_RW;
        default: s_next = s_next;
      endcase
    end
    // R1: disabled window claims outside downstream
    // R2: enabled window claims inside range only
    s_next.claim = SEC_MEM_VALID && !DOWN_WIN_HIT && (!s_reg.win_en || win_hit);
    // R14: report unmasked events when enabled
    // R15 R16 R17 R18 R19 R20: one mask bit each
    s_next.serr = system_error_report_enable && |(SERR_EVENTS & ~s_reg.serr_mask & SERR_MASK_RW);
  end

  // ****************************************
  // Register
  // ****************************************
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      s_reg <= '{win_en: 1'b0, preempt_code: PREEMPT_RESET, base_lo: BASE_RESET,
                 limit_lo: LIMIT_RESET, base_hi: UPPER_RESET, limit_hi: UPPER_RESET,
                 serr_mask: SERR_MASK_RESET, rdata: UPPER_RESET, rvalid: 1'b0,
                 claim: 1'b0, serr: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flip-flops; the timer output is its own register
  assign CFG_RDATA = s_reg.rdata;
  assign CFG_RVALID = s_reg.rvalid;
  assign UPSTREAM_CLAIM = s_reg.claim;
  assign PREEMPT_GRANT = preempt;
  assign primary_system_error_out = s_reg.serr;

endmodule

// File: upwin_cfg_assertions.sv
module upwin_cfg_assertions
  import upwin_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire cfg_req_t CFG_REQ,
  input wire logic [31:0] CFG_RDATA,
  input wire logic CFG_RVALID,
  input wire logic SEC_MEM_VALID,
  input wire logic DOWN_WIN_HIT,
  input wire logic UPSTREAM_CLAIM,
  input wire sec_bus_t SEC_BUS,
  input wire logic PREEMPT_GRANT,
  input wire logic [7:0] SERR_EVENTS,
  input wire logic system_error_report_enable,
  input wire logic primary_system_error_out
);
  // ****************
  // Preemption code shadow
  // ****************
  logic [3:0] code_reg; // Code as last written
  logic [3:0] code_next;
  // Follows writes so the delay checks know the mode
  always_comb begin
    code_next = code_reg;
    if (CFG_REQ.wr && CFG_REQ.addr == OFF_PREEMPT && CFG_REQ.be[3]) begin
      code_next = CFG_REQ.wdata[31:28];
    end
  end
  // Cleared with the register itself
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      code_reg <= PRE_C0;
    end else begin
      code_reg <= code_next;
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // Frame opens in eight-cycle mode with no grant yet
  sequence frame_start_c4;
    $rose(SEC_BUS.frame) && code_reg == PRE_C4 && !PREEMPT_GRANT;
  endsequence
  sequence quiet_eight;
    !PREEMPT_GRANT [*8];
  endsequence
  chk_read_strobe: assert property (CFG_REQ.rd |=> CFG_RVALID ##1 (CFG_RVALID == $past(CFG_REQ.rd)))
    else $error("read strobe wrong");
  chk_strobe_cause: assert property (CFG_RVALID |-> $past(CFG_REQ.rd)) else $error("stray read strobe");
  chk_claim_downhit: assert property (SEC_MEM_VALID && DOWN_WIN_HIT |=> !UPSTREAM_CLAIM)
    else $error("claim inside downstream window");
  chk_claim_idle: assert property (!SEC_MEM_VALID |=> !UPSTREAM_CLAIM) else $error("claim without address");
  chk_serr_enable: assert property (!system_error_report_enable |=> !primary_system_error_out)
    else $error("error output while disabled");
  chk_serr_quiet: assert property (SERR_EVENTS[6:1] == 6'h00 |=> !primary_system_error_out)
    else $error("error output without event");
  chk_grant_req: assert property (!SEC_BUS.other_req [*2] |=> !PREEMPT_GRANT)
    else $error("grant removed with no requester");
  chk_preempt_off: assert property (code_reg[3] && $past(code_reg[3]) |-> !PREEMPT_GRANT)
    else $error("preemption while off");
  chk_delay_eight: assert property (frame_start_c4 |-> quiet_eight) else $error("preemption too early");
  chk_cap_nibbles: assert property (CFG_RVALID && $past(CFG_REQ.addr) == OFF_BASE_LIMIT |->
    CFG_RDATA[3:0] == ADDR_CAP_64 && CFG_RDATA[19:16] == ADDR_CAP_64) else $error("capability field wrong");
  chk_ctrl_reserved: assert property (CFG_RVALID && $past(CFG_REQ.addr) == OFF_UPWIN_CTRL |->
    CFG_RDATA[31:17] == 15'h0000) else $error("reserved control bits set");
endmodule
bind upwin_cfg upwin_cfg_assertions chk_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CFG_REQ(CFG_REQ),
  .CFG_RDATA(CFG_RDATA), .CFG_RVALID(CFG_RVALID), .SEC_MEM_VALID(SEC_MEM_VALID), .DOWN_WIN_HIT(DOWN_WIN_HIT),
  .UPSTREAM_CLAIM(UPSTREAM_CLAIM), .SEC_BUS(SEC_BUS), .PREEMPT_GRANT(PREEMPT_GRANT), .SERR_EVENTS(SERR_EVENTS),
  .system_error_report_enable(system_error_report_enable), .primary_system_error_out(primary_system_error_out));

// File: upwin_sec_master.sv
module upwin_sec_master
  import upwin_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [7:0] hold,
  input wire logic want,
  output sec_bus_t bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_reg; // Cycles of tenure still to run
  // Frame held for the tenure, idle (deasserted) otherwise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      left_reg <= 8'h00;
    end else if (go) begin
      left_reg <= hold;
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end
  end
  assign bus.frame = (left_reg != 8'h00);
  // A rival only asks while a tenure is in progress
  assign bus.other_req = bus.frame && want;
endmodule

// File: upwin_cfg_tb_top.sv
module upwin_cfg_tb_top
  import upwin_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Stimulus, tables and checks
  // ****************
  localparam logic [7:0] offs [7] = '{OFF_UPWIN_CTRL, OFF_PREEMPT, OFF_BASE_LIMIT, OFF_BASE_UPPER,
    OFF_LIMIT_UPPER, OFF_SERR_MASK, 8'h60};
  localparam logic [31:0] wmask [7] = '{32'h00010000, 32'hf0000000, 32'hfff0fff0, 32'hffffffff,
    32'hffffffff, 32'h0000007e, 32'h0};
  localparam logic [31:0] fixed [7] = '{32'h0, 32'h0, 32'h00010001, 32'h0, 32'h0, 32'h0, 32'h0};
  // Window edges: in, below, top, above, wrong upper word
  localparam logic [63:0] probe [5] = '{64'h1_1230_0000, 64'h1_122f_ffff, 64'h1_125f_ffff,
    64'h1_1260_0000, 64'h0_1240_0000};
  localparam logic [4:0] in_win = 5'h05;
  // Grant edge count after the frame starts, 0 for never; code 0 still costs the output register
  localparam int dly [9] = '{1, 1, 2, 4, 8, 16, 32, 64, 0};
  logic SYS_CLK = 1'b0;
  logic RST_N = 1'b0;
  cfg_req_t req = '0;
  logic [31:0] rdata;
  logic rvalid;
  logic [63:0] addr = 64'h0;
  logic mval = 1'b0;
  logic dhit = 1'b0;
  logic claim;
  sec_bus_t sbus;
  logic grant;
  logic [7:0] ev = 8'h00;
  logic en = 1'b0;
  logic serr;
  logic go = 1'b0;
  logic want = 1'b1;
  int bad_count = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'h55872135;
  logic [31:0] expq [$]; // Read results still owed
  initial begin
    forever #2 SYS_CLK = ~SYS_CLK;
  end
  upwin_cfg dut_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CFG_REQ(req), .CFG_RDATA(rdata), .CFG_RVALID(rvalid),
    .SEC_ADDR(addr), .SEC_MEM_VALID(mval), .DOWN_WIN_HIT(dhit), .UPSTREAM_CLAIM(claim), .SEC_BUS(sbus),
    .PREEMPT_GRANT(grant), .SERR_EVENTS(ev), .system_error_report_enable(en), .primary_system_error_out(serr));
  upwin_sec_master master_u (.clk(SYS_CLK), .rst_n(RST_N), .go(go), .hold(8'h5a), .want(want), .bus(sbus));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (bad_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One-cycle configuration request, full byte enables
  task automatic cfg(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    req <= '{w, !w, a, d, 4'hf};
    @(posedge SYS_CLK);
    req <= '0;
  endtask
  // Start a tenure and count edges until the grant is pulled
  task automatic try_preempt(input int exp);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    go <= 1'b1;
    @(posedge SYS_CLK);
    go <= 1'b0;
    while (n < 80 && grant !== 1'b1) begin
      @(posedge SYS_CLK);
      #1;
      n++;
    end
    check((grant === 1'b1) ? n : 0, exp);
    repeat (100) @(posedge SYS_CLK);
  endtask
  // Read data checked against the oldest owed value
  always @(posedge SYS_CLK) begin
    if (rvalid === 1'b1) begin
      check(rdata, (expq.size() > 0) ? expq.pop_front() : 32'hx);
    end
  end
  initial begin
    logic [31:0] v;
    repeat (12) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    // Reset values, then all ones, then random words
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < 7; i++) begin
        seed = lfsr(seed);
        v = (p == 0) ? 32'h0 : (p == 1) ? 32'hffffffff : seed;
        if (p > 0) begin
          cfg(1'b1, offs[i], v);
        end
        expq.push_back((v & wmask[i]) | fixed[i]);
        cfg(1'b0, offs[i], 32'h0);
      end
    end
    // Window of 1 MB steps, disabled then enabled
    cfg(1'b1, OFF_BASE_LIMIT, 32'h12501230);
    cfg(1'b1, OFF_BASE_UPPER, 32'h1);
    cfg(1'b1, OFF_LIMIT_UPPER, 32'h1);
    for (int e = 0; e < 2; e++) begin
      cfg(1'b1, OFF_UPWIN_CTRL, (e == 1) ? 32'h00010000 : 32'h0);
      for (int i = 0; i < 5; i++) begin
        seed = lfsr(seed);
        @(posedge SYS_CLK);
        addr <= probe[i];
        mval <= 1'b1;
        dhit <= seed[0];
        @(posedge SYS_CLK);
        #1;
        check(32'(claim), 32'(!seed[0] && (e == 0 || in_win[i])));
      end
    end
    // Preemption codes 0 to 8, then a tenure with no rival
    for (int c = 0; c < 9; c++) begin
      cfg(1'b1, OFF_PREEMPT, {c[3:0], 28'h0});
      try_preempt(dly[c]);
    end
    want <= 1'b0;
    cfg(1'b1, OFF_PREEMPT, 32'h0);
    try_preempt(0);
    // Each event: open, disabled, own mask, other masks
    for (int b = 1; b < 7; b++) begin
      for (int k = 0; k < 4; k++) begin
        cfg(1'b1, OFF_SERR_MASK, (k == 2) ? 32'(8'h01 << b) : (k == 3) ? 32'(8'h7e & ~(8'h01 << b)) : 32'h0);
        @(posedge SYS_CLK);
        en <= (k != 1);
        ev <= 8'h01 << b;
        @(posedge SYS_CLK);
        #1;
        check(32'(serr), 32'(k == 0 || k == 3));
      end
    end
    // Every owed read must have come back
    check(32'(expq.size()), 32'h0);
    results();
  end
  // Hang guard, far beyond the roughly 1500 cycles needed
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    bad_count++;
    results();
  end
endmodule
